/* rtl/eci_pkg.sv */
package eci_pkg;
	// apb byte addresses
	localparam logic [7:0] ADDR_RESET_CAUSE_AND_PRIORITY_CONTROL  = 8'h00;
	localparam logic [7:0] ADDR_ICON1 = 8'h04;
	localparam logic [7:0] ADDR_ICON2 = 8'h08;
	localparam logic [7:0] ADDR_ICON3 = 8'h0C;
	localparam logic [7:0] ADDR_CHANGE_PIN_ENABLE_MASK  = 8'h10;
	localparam logic [7:0] ADDR_STAT  = 8'h14;
	localparam logic [7:0] ADDR_FRET  = 8'h18;
	// reset values, then the write mask of reset cause and priority control
	localparam logic [7:0] RESET_CAUSE_AND_PRIORITY_CONTROL_RST  = 8'h5C;
	localparam logic [7:0] ICON1_RST = 8'h00;
	localparam logic [7:0] ICON2_RST = 8'hF5;
	localparam logic [7:0] ICON3_RST = 8'hC0;
	localparam logic [7:0] CHANGE_PIN_ENABLE_MASK_RST  = 8'h00;
	localparam logic [7:0] RESET_CAUSE_AND_PRIORITY_CONTROL_WMASK = 8'hD3;
	// int_ctrl_one fields
	localparam int B_GIE   = 7;
	localparam int B_PERIPHERAL_INT_ENABLE  = 6;
	localparam int B_T0IE  = 5;
	localparam int B_I0E   = 4;
	localparam int B_PORTB_CHANGE_INT_ENABLE  = 3;
	localparam int B_T0IF  = 2;
	localparam int B_I0F   = 1;
	localparam int B_PORTB_CHANGE_FLAG  = 0;
	// int_ctrl_two fields
	localparam int B_EDG0  = 6;
	localparam int B_T0IP  = 2;
	localparam int B_PORTB_CHANGE_PRIORITY  = 0;
	// int_ctrl_three fields, then reset cause and priority control fields
	localparam int B_I2IP  = 7;
	localparam int B_I1IP  = 6;
	localparam int B_I2E   = 4;
	localparam int B_I1E   = 3;
	localparam int B_I2F   = 1;
	localparam int B_I1F   = 0;
	localparam int B_PRIORITY_LEVELS_ENABLE  = 7;
	localparam int B_RSV5  = 5;
	typedef enum logic [2:0] {
		ST_RUN   = 3'b001,
		ST_SLEEP = 3'b010,
		ST_ENTRY = 3'b100
	} eci_state_t;
endpackage

/* rtl/eci_top.sv */
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module eci_top #(
	parameter int PC_W = 21
) (
	// clock and reset
	input  wire logic            sys_clk_i,
	input  wire logic            reset_n_i,
	// apb slave
	input  wire logic            psel_i,
	input  wire logic            penable_i,
	input  wire logic            pwrite_i,
	input  wire logic [7:0]      paddr_i,
	input  wire logic [31:0]     pwdata_i,
	output logic      [31:0]     prdata_o,
	output logic                 pready_o,
	output logic                 pslverr_o,
	// event sources
	input  wire logic [2:0]      ext_pin_i,
	input  wire logic [3:0]      portb_hi_i,
	input  wire logic            timer_tick_i,
	input  wire logic            timer_16bit_i,
	input  wire logic [15:0]     timer_count_i,
	input  wire logic            periph_req_hi_i,
	input  wire logic            periph_req_lo_i,
	// reset cause inputs from reset block
	input  wire logic            wdt_timeout_i,
	input  wire logic            powerdown_i,
	// core side
	input  wire logic            sleep_req_i,
	input  wire logic            core_ack_i,
	input  wire logic [PC_W-1:0] return_pc_i,
	input  wire logic [7:0]      working_register_i,
	input  wire logic [7:0]      status_i,
	input  wire logic [7:0]      bank_select_register_i,
	output logic                 wake_o,
	output logic                 vector_hi_o,
	output logic                 vector_lo_o,
	output logic                 sleeping_o,
	output logic                 stack_push_o,
	output logic [PC_W-1:0]      stack_pc_o,
	output logic [7:0]           fast_working_o,
	output logic [7:0]           fast_status_o,
	output logic [7:0]           fast_bank_o
);
	logic [7:0]   reset_cause_and_priority_control;
	logic [7:0]   icon1;
	logic [7:0]   icon2;
	logic [7:0]   icon3;
	logic [7:0]   change_pin_enable_mask;
	logic [2:0]   ext_q;
	logic [3:0]   pb_q;
	logic [15:0]  tmr_q;
	logic         tick_q;
	eci_pkg::eci_state_t state;
	eci_pkg::eci_state_t next_state;

	wire wr_en = psel_i & penable_i & pwrite_i;
	wire [7:0] wd = pwdata_i[7:0];
	wire sel_reset_cause_and_priority_control  = paddr_i == eci_pkg::ADDR_RESET_CAUSE_AND_PRIORITY_CONTROL;
	wire sel_icon1 = paddr_i == eci_pkg::ADDR_ICON1;
	wire sel_icon2 = paddr_i == eci_pkg::ADDR_ICON2;
	wire sel_icon3 = paddr_i == eci_pkg::ADDR_ICON3;
	wire sel_change_pin_enable_mask  = paddr_i == eci_pkg::ADDR_CHANGE_PIN_ENABLE_MASK;
	wire sel_stat  = paddr_i == eci_pkg::ADDR_STAT;
	wire sel_fret  = paddr_i == eci_pkg::ADDR_FRET;
	wire mapped = sel_reset_cause_and_priority_control | sel_icon1 | sel_icon2 | sel_icon3 | sel_change_pin_enable_mask | sel_stat | sel_fret;

	// edge detect: per-pin polarity from edge select bits
	wire [2:0] edge_sel = {icon2[eci_pkg::B_EDG0-2], icon2[eci_pkg::B_EDG0-1], icon2[eci_pkg::B_EDG0]};
	wire [2:0] rise = ext_pin_i & ~ext_q;
	wire [2:0] fall = ~ext_pin_i & ext_q;
	wire [2:0] ext_hit = (edge_sel & rise) | (~edge_sel & fall);
	wire [3:0] pb_chg = portb_hi_i ^ pb_q;

	// overflow seen as wrap of the counter while ticking
	wire ovf8  = tick_q & (tmr_q[7:0] == 8'hFF) & (timer_count_i[7:0] == 8'h00);
	wire ovf16 = tick_q & (tmr_q == 16'hFFFF) & (timer_count_i == 16'h0000);
	wire tmr_ovf = timer_16bit_i ? ovf16 : ovf8;

	// flag AND enable; request persists until the flag is cleared
	wire r_i0 = icon1[eci_pkg::B_I0F] & icon1[eci_pkg::B_I0E];
	wire r_i1 = icon3[eci_pkg::B_I1F] & icon3[eci_pkg::B_I1E];
	wire r_i2 = icon3[eci_pkg::B_I2F] & icon3[eci_pkg::B_I2E];
	wire r_t0 = icon1[eci_pkg::B_T0IF] & icon1[eci_pkg::B_T0IE];
	wire r_rb = icon1[eci_pkg::B_PORTB_CHANGE_FLAG] & icon1[eci_pkg::B_PORTB_CHANGE_INT_ENABLE];
	wire priority_levels_enable = reset_cause_and_priority_control[eci_pkg::B_PRIORITY_LEVELS_ENABLE];
	wire global_int_enable  = icon1[eci_pkg::B_GIE];
	wire peripheral_int_enable = icon1[eci_pkg::B_PERIPHERAL_INT_ENABLE];

	wire p_i1 = icon3[eci_pkg::B_I1IP];
	wire p_i2 = icon3[eci_pkg::B_I2IP];
	wire p_t0 = icon2[eci_pkg::B_T0IP];
	wire p_rb = icon2[eci_pkg::B_PORTB_CHANGE_PRIORITY];
	// int0 has no priority bit, always high
	wire any_hi = r_i0 | (r_i1 & p_i1) | (r_i2 & p_i2) | (r_t0 & p_t0) | (r_rb & p_rb) | periph_req_hi_i;
	wire any_lo = (r_i1 & ~p_i1) | (r_i2 & ~p_i2) | (r_t0 & ~p_t0) | (r_rb & ~p_rb) | periph_req_lo_i;
	wire core_any = r_i0 | r_i1 | r_i2 | r_t0 | r_rb;
	// compatibility mode: one level, peripherals gated by peripheral enable
	wire legacy_req = core_any | (peripheral_int_enable & (periph_req_hi_i | periph_req_lo_i));
	// low level uses the peripheral enable bit as its global enable in priority mode
	wire vec_hi = priority_levels_enable ? (global_int_enable & any_hi) : (global_int_enable & legacy_req);
	wire vec_lo = priority_levels_enable & peripheral_int_enable & any_lo & ~any_hi;
	wire wake_src = priority_levels_enable ? (any_hi | any_lo) : legacy_req;

	// sticky flags: a hardware set wins over a software clear
	wire [7:0] icon1_sw = (wr_en & sel_icon1) ? wd : icon1;
	wire [7:0] icon1_set = {5'h00, tmr_ovf, ext_hit[0], |(pb_chg & change_pin_enable_mask[7:4])};
	wire [7:0] icon3_sw = (wr_en & sel_icon3) ? wd : icon3;
	wire [7:0] icon3_set = {6'h00, ext_hit[2], ext_hit[1]};
	wire [7:0] next_reset_cause_and_priority_control = (wr_en & sel_reset_cause_and_priority_control) ?
		((wd & eci_pkg::RESET_CAUSE_AND_PRIORITY_CONTROL_WMASK) | (reset_cause_and_priority_control & ~eci_pkg::RESET_CAUSE_AND_PRIORITY_CONTROL_WMASK)) : reset_cause_and_priority_control;

	always_comb begin
		next_state = state;
		unique case (state)
			eci_pkg::ST_RUN: begin
				if (vec_hi | vec_lo) next_state = eci_pkg::ST_ENTRY;
				else if (sleep_req_i) next_state = eci_pkg::ST_SLEEP;
			end
			eci_pkg::ST_SLEEP: begin
				if (wake_src) next_state = (vec_hi | vec_lo) ? eci_pkg::ST_ENTRY : eci_pkg::ST_RUN;
			end
			eci_pkg::ST_ENTRY: begin
				if (core_ack_i) next_state = eci_pkg::ST_RUN;
			end
			default: next_state = eci_pkg::ST_RUN;
		endcase
	end

	wire entering = (state != eci_pkg::ST_ENTRY) && (next_state == eci_pkg::ST_ENTRY);

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			reset_cause_and_priority_control  <= eci_pkg::RESET_CAUSE_AND_PRIORITY_CONTROL_RST;
			icon1 <= eci_pkg::ICON1_RST;
			icon2 <= eci_pkg::ICON2_RST;
			icon3 <= eci_pkg::ICON3_RST;
			change_pin_enable_mask  <= eci_pkg::CHANGE_PIN_ENABLE_MASK_RST;
			ext_q <= 3'h0;
			pb_q  <= 4'h0;
			tmr_q <= 16'h0000;
			tick_q <= 1'b0;
			state <= eci_pkg::ST_RUN;
		end else begin
			// watchdog and power-down flags follow the reset block only
			reset_cause_and_priority_control  <= {next_reset_cause_and_priority_control[7:4], wdt_timeout_i, powerdown_i, next_reset_cause_and_priority_control[1:0]};
			icon1 <= icon1_sw | icon1_set;
			icon2 <= (wr_en & sel_icon2) ? wd : icon2;
			icon3 <= icon3_sw | icon3_set;
			change_pin_enable_mask  <= (wr_en & sel_change_pin_enable_mask) ? wd : change_pin_enable_mask;
			ext_q <= ext_pin_i;
			pb_q  <= portb_hi_i;
			tmr_q <= timer_count_i;
			tick_q <= timer_tick_i;
			state <= next_state;
		end
	end

	// context capture on entry
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			stack_push_o   <= 1'b0;
			stack_pc_o     <= '0;
			fast_working_o <= 8'h00;
			fast_status_o  <= 8'h00;
			fast_bank_o    <= 8'h00;
			vector_hi_o    <= 1'b0;
			vector_lo_o    <= 1'b0;
			wake_o         <= 1'b0;
		end else begin
			stack_push_o <= entering;
			wake_o <= (state == eci_pkg::ST_SLEEP) & wake_src;
			if (entering) begin
				stack_pc_o     <= return_pc_i;
				fast_working_o <= working_register_i;
				fast_status_o  <= status_i;
				fast_bank_o    <= bank_select_register_i;
				vector_hi_o    <= vec_hi;
				vector_lo_o    <= ~vec_hi;
			end else if (core_ack_i) begin
				vector_hi_o <= 1'b0;
				vector_lo_o <= 1'b0;
			end
		end
	end

	assign sleeping_o = state == eci_pkg::ST_SLEEP;
	assign pready_o   = 1'b1;
	assign pslverr_o  = psel_i & penable_i & ~mapped;

	// reserved bit 5 forced low on read
	wire [7:0] rd_byte =
		sel_reset_cause_and_priority_control  ? (reset_cause_and_priority_control & ~(8'h01 << eci_pkg::B_RSV5)) :
		sel_icon1 ? icon1 :
		sel_icon2 ? icon2 :
		sel_icon3 ? icon3 :
		sel_change_pin_enable_mask  ? change_pin_enable_mask :
		sel_stat  ? {3'h0, state, vec_hi, vec_lo} :
		sel_fret  ? fast_bank_o : 8'h00;
	assign prdata_o = {24'h000000, rd_byte};
endmodule
`default_nettype wire

/* tb/eci_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module eci_core_model (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	// vector handshake
	input wire logic slow_i,
	input wire logic vector_hi_i,
	input wire logic vector_lo_i,
	output logic     core_ack_o
);
	logic [3:0] wait_cnt;
	// a slow core lets the vector stand several cycles before taking it
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wait_cnt <= 4'h0;
			core_ack_o <= 1'b0;
		end else begin
			core_ack_o <= 1'b0;
			if ((vector_hi_i || vector_lo_i) && !core_ack_o) begin
				wait_cnt <= wait_cnt + 4'h1;
				if (wait_cnt >= (slow_i ? 4'h6 : 4'h0)) begin
					core_ack_o <= 1'b1;
					wait_cnt <= 4'h0;
				end
			end
		end
	end
endmodule
`default_nettype wire

/* tb/eci_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module eci_sva #(
	parameter int PC_W = 21
) (
	// clock and reset
	input wire logic            sys_clk_i,
	input wire logic            reset_n_i,
	// apb
	input wire logic            psel_i,
	input wire logic            penable_i,
	input wire logic            pwrite_i,
	input wire logic [7:0]      paddr_i,
	input wire logic [31:0]     prdata_o,
	input wire logic            pslverr_o,
	// core side
	input wire logic            core_ack_i,
	input wire logic [PC_W-1:0] return_pc_i,
	input wire logic [7:0]      working_register_i,
	input wire logic [7:0]      status_i,
	input wire logic [7:0]      bank_select_register_i,
	input wire logic            vector_hi_o,
	input wire logic            vector_lo_o,
	input wire logic            stack_push_o,
	input wire logic [PC_W-1:0] stack_pc_o,
	input wire logic [7:0]      fast_working_o,
	input wire logic [7:0]      fast_status_o,
	input wire logic [7:0]      fast_bank_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	wire acc = psel_i && penable_i;
	AST_UNMAPPED: assert property (acc && paddr_i > 8'h18 |-> pslverr_o && (pwrite_i || prdata_o == 32'h0))
		else $error("unmapped access not refused");
	AST_RSV5: assert property (acc && !pwrite_i && paddr_i == 8'h00 |-> !prdata_o[5])
		else $error("reserved bit reads one");
	AST_PUSH_ONCE: assert property (stack_push_o |=> !stack_push_o)
		else $error("push longer than one cycle");
	AST_PUSH_PC: assert property (stack_push_o |-> stack_pc_o == $past(return_pc_i))
		else $error("wrong return address pushed");
	AST_FAST_CTX: assert property (stack_push_o |-> {fast_working_o, fast_status_o, fast_bank_o} ==
		$past({working_register_i, status_i, bank_select_register_i})) else $error("fast context wrong");
	AST_VEC_ENTRY: assert property ($rose(vector_hi_o || vector_lo_o) |-> stack_push_o)
		else $error("vector without push");
	AST_VEC_HOLD: assert property (vector_hi_o && !core_ack_i |=> vector_hi_o)
		else $error("vector dropped before ack");
	AST_ONE_LEVEL: assert property (!(vector_hi_o && vector_lo_o))
		else $error("both vectors at once");
endmodule
bind eci_top eci_sva #(.PC_W(PC_W)) u_sva (.sys_clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
	.prdata_o, .pslverr_o, .core_ack_i, .return_pc_i, .working_register_i, .status_i, .bank_select_register_i,
	.vector_hi_o, .vector_lo_o, .stack_push_o, .stack_pc_o, .fast_working_o, .fast_status_o, .fast_bank_o);
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, tick = 1'b0, mode16 = 1'b0;
	logic wdt = 1'b1, pdn = 1'b1, sleep_req = 1'b0, slow = 1'b1, periph_hi = 1'b0, e;
	logic [7:0] paddr = 8'h00, ctx = 8'h3C, f_w, f_s, f_b;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic [2:0] pin = 3'h0;
	logic [3:0] portb = 4'h0;
	logic [15:0] count = 16'h0;
	logic pready, pslverr, ack, wake, vec_hi, vec_lo, sleeping, push;
	logic [20:0] stack_pc;
	int err_count = 0, total_checks = 0, i;
	eci_top DUT (.sys_clk_i(clk), .reset_n_i(rst_n), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.ext_pin_i(pin), .portb_hi_i(portb), .timer_tick_i(tick), .timer_16bit_i(mode16), .timer_count_i(count),
		.periph_req_hi_i(periph_hi), .periph_req_lo_i(1'b0), .wdt_timeout_i(wdt), .powerdown_i(pdn),
		.sleep_req_i(sleep_req), .core_ack_i(ack), .return_pc_i({13'h0, ctx}), .working_register_i(ctx),
		.status_i(~ctx), .bank_select_register_i(ctx ^ 8'h5A), .wake_o(wake), .vector_hi_o(vec_hi),
		.vector_lo_o(vec_lo), .sleeping_o(sleeping), .stack_push_o(push), .stack_pc_o(stack_pc),
		.fast_working_o(f_w), .fast_status_o(f_s), .fast_bank_o(f_b));
	eci_core_model u_core (.sys_clk_i(clk), .reset_n_i(rst_n), .slow_i(slow), .vector_hi_i(vec_hi),
		.vector_lo_i(vec_lo), .core_ack_o(ack));
	initial begin
		forever #12.5 clk = ~clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		apb(1'b0, a, 8'h00);
		chk({24'h0, q[7:0]}, {24'h0, exp});
	endtask
	// bounded wait for any of vector high, vector low, wake
	task automatic wait_on(input logic [2:0] sel);
		repeat (40) if (({vec_hi, vec_lo, wake} & sel) == 3'h0) @(posedge clk);
	endtask
	task automatic finish_test;
		if (err_count == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk);
		err_count++;
		finish_test();
	end
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rd(8'h00, 8'h5C);
		rd(8'h08, 8'hF5);
		rd(8'h0C, 8'hC0);
		rd(8'h40, 8'h00);
		chk({31'h0, e}, 32'h1);
		wr(8'h00, 8'hFF);
		rd(8'h00, 8'hDF);
		wr(8'h00, 8'h00);
		rd(8'h00, 8'h0C);
		wr(8'h04, 8'h90);
		pin[0] <= 1'b1;
		wait_on(3'h6);
		chk({vec_hi | vec_lo, stack_pc}, {1'b1, 13'h0, ctx});
		chk({f_w, f_s, f_b}, {ctx, ~ctx, ctx ^ 8'h5A});
		rd(8'h04, 8'h92);
		wr(8'h04, 8'h00);
		pin[0] <= 1'b0;
		slow <= 1'b0;
		ctx <= 8'hA5;
		wr(8'h08, 8'hD5);
		pin[1] <= 1'b1;
		rd(8'h0C, 8'hC0);
		pin[1] <= 1'b0;
		repeat (2) @(posedge clk);
		rd(8'h0C, 8'hC1);
		chk({30'h0, vec_hi, vec_lo}, 32'h0);
		wr(8'h0C, 8'h00);
		wr(8'h00, 8'h80);
		// ext1 low, ext1 high, then ext0 which has no priority bit
		for (i = 0; i < 3; i++) begin
			wr(8'h04, (i == 2) ? 8'hD0 : 8'hC0);
			wr(8'h0C, (i == 1) ? 8'h48 : 8'h08);
			pin <= (i == 2) ? 3'h1 : 3'h2;
			repeat (2) @(posedge clk);
			pin <= 3'h0;
			wait_on(3'h6);
			chk({30'h0, vec_hi, vec_lo}, (i == 0) ? 32'h1 : 32'h2);
			chk({f_w, f_s, f_b}, {ctx, ~ctx, ctx ^ 8'h5A});
			wr(8'h0C, 8'h00);
			wr(8'h04, 8'h00);
			repeat (4) @(posedge clk);
		end
		for (i = 0; i < 3; i++) begin
			mode16 <= (i != 0);
			tick <= 1'b1;
			count <= (i == 1) ? 16'h00FF : 16'hFFFF;
			@(posedge clk);
			count <= (i == 1) ? 16'h0100 : 16'h0000;
			@(posedge clk);
			tick <= 1'b0;
			rd(8'h04, (i == 1) ? 8'h00 : 8'h04);
			wr(8'h04, 8'h00);
		end
		wr(8'h10, 8'hF0);
		portb <= 4'h8;
		rd(8'h10, 8'hF0);
		rd(8'h04, 8'h01);
		wr(8'h00, 8'h00);
		// single level: a peripheral request needs the peripheral enable
		wr(8'h04, 8'h80);
		periph_hi <= 1'b1;
		repeat (2) @(posedge clk);
		chk({30'h0, vec_hi, vec_lo}, 32'h0);
		wr(8'h04, 8'hC0);
		wait_on(3'h6);
		chk({30'h0, vec_hi, vec_lo}, 32'h2);
		periph_hi <= 1'b0;
		wr(8'h04, 8'h10);
		sleep_req <= 1'b1;
		repeat (3) @(posedge clk);
		chk({31'h0, sleeping}, 32'h1);
		pin[0] <= 1'b1;
		wait_on(3'h1);
		chk({29'h0, vec_hi, vec_lo, wake}, 32'h1);
		sleep_req <= 1'b0;
		repeat (4) @(posedge clk);
		finish_test();
	end
endmodule
`default_nettype wire
